// file: gpio_fgh_pkg.sv
`default_nettype none
package gpio_fgh_pkg;
  // Register word indices, taken from byte address bits [5:2]
  localparam logic [3:0] idx_port_f_data = 4'h9;
  localparam logic [3:0] idx_port_g_data = 4'hA;
  localparam logic [3:0] idx_port_h_data = 4'hB;
  localparam logic [3:0] idx_port_f_dir  = 4'hC;
  localparam logic [3:0] idx_port_g_dir  = 4'hD;
  localparam logic [3:0] idx_port_h_dir  = 4'hE;
  // Port widths
  localparam int f_width = 7;
  localparam int g_width = 3;
  localparam int h_width = 2;
  // Timer-owned port F bits and keypad enable positions
  localparam int f_timer_lo = 4;
  localparam int kbd_g_lo   = 0;
  localparam int kbd_h_lo   = 3;
  // Direction values after reset
  localparam logic [6:0] f_dir_reset = 7'h00;
  localparam logic [2:0] g_dir_reset = 3'h0;
  localparam logic [1:0] h_dir_reset = 2'h0;
  // Timer edge/level select value meaning pin is general purpose
  localparam logic [1:0] els_gpio = 2'h0;
endpackage : gpio_fgh_pkg
`default_nettype wire

// file: gpio_ports_f_g_h.sv
`default_nettype none
module gpio_ports_f_g_h
  import gpio_fgh_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  input  wire logic [6:0]  port_f_in,
  output logic      [6:0]  port_f_out,
  output logic      [6:0]  port_f_oe_n,
  input  wire logic [2:0]  port_g_in,
  output logic      [2:0]  port_g_out,
  output logic      [2:0]  port_g_oe_n,
  input  wire logic [1:0]  port_h_in,
  output logic      [1:0]  port_h_out,
  output logic      [1:0]  port_h_oe_n,
  input  wire logic [1:0]  timer_edge_level_select_0,
  input  wire logic [1:0]  timer_edge_level_select_1,
  input  wire logic [1:0]  timer_b_channel_out,
  output logic      [1:0]  timer_b_channel_pin,
  input  wire logic [4:0]  keypad_irq_enable,
  output logic      [4:0]  keypad_wakeup_pin
);
  import gpio_fgh_pkg::*;

  // Directions are reset; latches are kept out of the reset
  typedef struct packed {
    logic [6:0]  f_dir;
    logic [2:0]  g_dir;
    logic [1:0]  h_dir;
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } ctrl_type;

  typedef struct packed {
    logic [6:0] f_lat;
    logic [2:0] g_lat;
    logic [1:0] h_lat;
  } latch_type;

  ctrl_type  state;
  ctrl_type  next_state;
  latch_type lat;
  latch_type next_lat;

  logic       req;
  logic       wr_lane0;
  logic [3:0] idx;
  logic       hit;
  logic [1:0] timer_owned;
  logic [6:0] f_drive;
  logic [2:0] g_drive;
  logic [1:0] h_drive;
  logic [6:0] f_read;
  logic [2:0] g_read;
  logic [1:0] h_read;

  // New request only when no answer is standing
  assign req      = wb_cyc_i && wb_stb_i && !state.ack && !state.err;
  assign wr_lane0 = req && wb_we_i && wb_sel_i[0];
  assign idx      = wb_adr_i[5:2];
  assign hit      = (wb_adr_i[1:0] == 2'h0) &&
                    (idx >= idx_port_f_data) && (idx <= idx_port_h_dir);

  assign timer_owned[0] = timer_edge_level_select_0 != els_gpio;
  assign timer_owned[1] = timer_edge_level_select_1 != els_gpio;

  // Timer overrides direction on owned pins
  always_comb
  begin
    f_drive = state.f_dir;
    port_f_out = lat.f_lat;
    for (int i = 0; i < 2; i++)
    begin
      if (timer_owned[i])
      begin
        f_drive[f_timer_lo + i]    = 1'b1;
        port_f_out[f_timer_lo + i] = timer_b_channel_out[i];
      end
    end
  end

  // Owned pins carry the timer, free pins follow direction
  timer_f4_drive_a: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    timer_owned[0] |-> !port_f_oe_n[4] &&
    port_f_out[4] == timer_b_channel_out[0])
    else $error("timer pin f4 not driven");
  timer_f5_drive_a: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    timer_owned[1] |-> !port_f_oe_n[5] &&
    port_f_out[5] == timer_b_channel_out[1])
    else $error("timer pin f5 not driven");
  gpio_f4_dir_a: assert property (@(posedge sys_clk)
    disable iff (!nrst) !timer_owned[0] |->
    port_f_oe_n[4] == !state.f_dir[4])
    else $error("gpio pin f4 direction ignored");
  gpio_f5_dir_a: assert property (@(posedge sys_clk)
    disable iff (!nrst) !timer_owned[1] |->
    port_f_oe_n[5] == !state.f_dir[5])
    else $error("gpio pin f5 direction ignored");
  f_low_dir_a: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    port_f_oe_n[3:0] == ~state.f_dir[3:0])
    else $error("port f low pins ignore direction");
  f_top_dir_a: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    port_f_oe_n[6] == !state.f_dir[6])
    else $error("port f pin 6 ignores direction");

  // Keypad enable forces port G input
  assign g_drive = state.g_dir & ~keypad_irq_enable[kbd_g_lo +: g_width];
  // Keypad enable forces port H input
  assign h_drive = state.h_dir & ~keypad_irq_enable[kbd_h_lo +: h_width];

  assign port_f_oe_n = ~f_drive;
  assign port_g_oe_n = ~g_drive;
  assign port_h_oe_n = ~h_drive;
  assign port_g_out  = lat.g_lat;
  assign port_h_out  = lat.h_lat;

  // Keypad use must always leave the pin undriven
  g_keypad_input_a: assert property (@(posedge sys_clk)
    disable iff (!nrst) keypad_irq_enable[0] |-> port_g_oe_n[0])
    else $error("keypad pin g0 driven");
  g_keypad_in1_a: assert property (@(posedge sys_clk)
    disable iff (!nrst) keypad_irq_enable[1] |-> port_g_oe_n[1])
    else $error("keypad pin g1 driven");
  g_keypad_in2_a: assert property (@(posedge sys_clk)
    disable iff (!nrst) keypad_irq_enable[2] |-> port_g_oe_n[2])
    else $error("keypad pin g2 driven");
  h_keypad_in3_a: assert property (@(posedge sys_clk)
    disable iff (!nrst) keypad_irq_enable[3] |-> port_h_oe_n[0])
    else $error("keypad pin h0 driven");
  h_keypad_input_a: assert property (@(posedge sys_clk)
    disable iff (!nrst) keypad_irq_enable[4] |-> port_h_oe_n[1])
    else $error("keypad pin h1 driven");
  g_dir_drive_a: assert property (@(posedge sys_clk)
    disable iff (!nrst) keypad_irq_enable[2:0] == 3'h0 |->
    port_g_oe_n == ~state.g_dir)
    else $error("port g ignores direction");
  h_dir_drive_a: assert property (@(posedge sys_clk)
    disable iff (!nrst) keypad_irq_enable[4:3] == 2'h0 |->
    port_h_oe_n == ~state.h_dir)
    else $error("port h ignores direction");

  // Pin levels handed to the peripherals
  assign timer_b_channel_pin = port_f_in[f_timer_lo +: 2];
  assign keypad_wakeup_pin   = {port_h_in, port_g_in};

  // Port F, G and H reads selected by direction alone
  assign f_read = (state.f_dir & lat.f_lat) | (~state.f_dir & port_f_in);
  assign g_read = (state.g_dir & lat.g_lat) | (~state.g_dir & port_g_in);
  assign h_read = (state.h_dir & lat.h_lat) | (~state.h_dir & port_h_in);

  // Read answers carry the mux value, upper bits zero
  f_read_mux_a: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    req && !wb_we_i && idx == idx_port_f_data && wb_adr_i[1:0] == 2'h0
    |=> wb_dat_o == {25'h0, $past(f_read)})
    else $error("port f read wrong");
  g_read_mux_a: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    req && !wb_we_i && idx == idx_port_g_data && wb_adr_i[1:0] == 2'h0
    |=> wb_dat_o == {29'h0, $past(g_read)})
    else $error("port g read wrong");
  h_read_mux_a: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    req && !wb_we_i && idx == idx_port_h_data && wb_adr_i[1:0] == 2'h0
    |=> wb_dat_o == {30'h0, $past(h_read)})
    else $error("port h read wrong");
  f_dir_read_a: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    req && !wb_we_i && idx == idx_port_f_dir && wb_adr_i[1:0] == 2'h0
    |=> wb_dat_o == {25'h0, $past(state.f_dir)})
    else $error("port f direction read wrong");
  g_dir_read_a: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    req && !wb_we_i && idx == idx_port_g_dir && wb_adr_i[1:0] == 2'h0
    |=> wb_dat_o == {29'h0, $past(state.g_dir)})
    else $error("port g direction read wrong");
  h_dir_read_a: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    req && !wb_we_i && idx == idx_port_h_dir && wb_adr_i[1:0] == 2'h0
    |=> wb_dat_o == {30'h0, $past(state.h_dir)})
    else $error("port h direction read wrong");

  // Register writes and read answer; one-cycle ack then drop
  always_comb
  begin
    next_state = state;
    next_lat   = lat;
    next_state.ack = 1'b0;
    next_state.err = 1'b0;
    if (req)
    begin
      next_state.ack = hit;
      next_state.err = !hit;
      next_state.rdata = 32'h0000_0000;
      case (idx)
        idx_port_f_data: next_state.rdata[6:0] = f_read;
        idx_port_g_data: next_state.rdata[2:0] = g_read;
        idx_port_h_data: next_state.rdata[1:0] = h_read;
        idx_port_f_dir:  next_state.rdata[6:0] = state.f_dir;
        idx_port_g_dir:  next_state.rdata[2:0] = state.g_dir;
        idx_port_h_dir:  next_state.rdata[1:0] = state.h_dir;
        default:         next_state.rdata = 32'h0000_0000;
      endcase
      if (!hit || wb_we_i)
        next_state.rdata = 32'h0000_0000;
      if (wr_lane0 && hit)
      begin
        case (idx)
          idx_port_f_data: next_lat.f_lat = wb_dat_i[6:0];
          idx_port_g_data: next_lat.g_lat = wb_dat_i[2:0];
          idx_port_h_data: next_lat.h_lat = wb_dat_i[1:0];
          idx_port_f_dir:  next_state.f_dir = wb_dat_i[6:0];
          idx_port_g_dir:  next_state.g_dir = wb_dat_i[2:0];
          idx_port_h_dir:  next_state.h_dir = wb_dat_i[1:0];
          default:         next_lat = lat;
        endcase
      end
    end
  end

  // Reset clears directions and bus answer
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state.f_dir <= f_dir_reset;
      state.g_dir <= g_dir_reset;
      state.h_dir <= h_dir_reset;
      state.ack   <= 1'b0;
      state.err   <= 1'b0;
      state.rdata <= 32'h0000_0000;
    end
    else
      state <= next_state;
  end

  // Latches have no reset, keep value
  always_ff @(posedge sys_clk)
  begin
    lat <= next_lat;
  end

  assign wb_ack_o = state.ack;
  assign wb_err_o = state.err;
  assign wb_dat_o = state.rdata;

  // Data writes land in the latches whatever the direction
  f_latch_write_a: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    wr_lane0 && hit && idx == idx_port_f_data
    |=> lat.f_lat == $past(wb_dat_i[6:0]))
    else $error("port f latch not written");
  latch_write_a: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    wr_lane0 && hit && idx == idx_port_g_data
    |=> lat.g_lat == $past(wb_dat_i[2:0]))
    else $error("port g latch not written");
  h_latch_write_a: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    wr_lane0 && hit && idx == idx_port_h_data
    |=> lat.h_lat == $past(wb_dat_i[1:0]))
    else $error("port h latch not written");

  // Direction writes keep only the implemented bits
  f_dir_write_a: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    wr_lane0 && hit && idx == idx_port_f_dir
    |=> state.f_dir == $past(wb_dat_i[6:0]))
    else $error("port f direction not written");
  g_dir_write_a: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    wr_lane0 && hit && idx == idx_port_g_dir
    |=> state.g_dir == $past(wb_dat_i[2:0]))
    else $error("port g direction not written");
  h_dir_write_a: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    wr_lane0 && hit && idx == idx_port_h_dir
    |=> state.h_dir == $past(wb_dat_i[1:0]))
    else $error("port h direction not written");

  // Bus answer shape: one pulse, err for holes, no side effect
  ack_pulse_a: assert property (@(posedge sys_clk)
    disable iff (!nrst) wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  unmapped_err_a: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    req && !hit |=> wb_err_o && !wb_ack_o)
    else $error("unmapped access not refused");
  err_no_write_a: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    req && !hit |=> $stable(state.f_dir) && $stable(state.g_dir) &&
    $stable(state.h_dir))
    else $error("refused access changed a direction");

  // Every pin not owned by the timer is an input right after reset
  dir_reset_a: assert property (@(posedge sys_clk)
    $rose(nrst) |-> state.f_dir == 7'h00 && state.g_dir == 3'h0 &&
    state.h_dir == 2'h0)
    else $error("directions not cleared");
endmodule : gpio_ports_f_g_h
`default_nettype wire

// file: pin_model.sv
`default_nettype none
module pin_model
(
  input  wire logic [11:0] pin_out,
  input  wire logic [11:0] pin_oe_n,
  input  wire logic [11:0] ext_drive,
  output logic      [11:0] pin_level
);
  timeunit 1ns;
  timeprecision 100ps;
  // Pin level: device wins while enabled, else the outside source
  always_comb
  begin
    for (int i = 0; i < 12; i++)
      pin_level[i] = pin_oe_n[i] ? ext_drive[i] : pin_out[i];
  end
endmodule : pin_model
`default_nettype wire

// file: gpio_ports_f_g_h_test.sv
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  num_errors++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module gpio_ports_f_g_h_test;
  import gpio_fgh_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk = 0, nrst = 0, cyc = 0, stb = 0, we = 0;
  logic        ack, err, got_err;
  logic [5:0]  adr = 6'h00;
  logic [31:0] dat_i = 32'h0, dat_o, q;
  logic [11:0] pins, outs, oe_n, ext = 12'h000;
  logic [1:0]  els0 = 2'h0, els1 = 2'h0, tmr = 2'h0, tbpin;
  logic [4:0]  kie = 5'h00, kwp;
  int          num_errors = 0, cmp_count = 0;
  // Half period 12.5 ns gives 40 MHz
  always #12.5 sys_clk = ~sys_clk;
  gpio_ports_f_g_h gpio_ports_f_g_h_i (.sys_clk(sys_clk), .nrst(nrst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .wb_err_o(err), .port_f_in(pins[6:0]), .port_f_out(outs[6:0]),
    .port_f_oe_n(oe_n[6:0]), .port_g_in(pins[9:7]),
    .port_g_out(outs[9:7]), .port_g_oe_n(oe_n[9:7]),
    .port_h_in(pins[11:10]), .port_h_out(outs[11:10]),
    .port_h_oe_n(oe_n[11:10]), .timer_edge_level_select_0(els0),
    .timer_edge_level_select_1(els1), .timer_b_channel_out(tmr),
    .timer_b_channel_pin(tbpin), .keypad_irq_enable(kie),
    .keypad_wakeup_pin(kwp));
  pin_model pin_model_i (.pin_out(outs), .pin_oe_n(oe_n),
    .ext_drive(ext), .pin_level(pins));
  task automatic report_and_stop;
    if (num_errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop
  // One classic cycle; held until ack or err is seen at an edge, or 20 edges pass
  task automatic xfer(input logic w, input logic [5:0] a,
                      input logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_i <= {24'h0, d};
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (ack !== 1'b1 && err !== 1'b1 && n < 20);
    if (n >= 20)
      num_errors++;
    q = dat_o;
    got_err = err;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : xfer
  task automatic rd(input string nm, input logic [5:0] a,
                    input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    `CHK(nm, {24'h0, e}, q)
  endtask : rd
  task automatic rst;
    nrst <= 1'b0;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
  endtask : rst
  // Hang guard, far beyond the fewer than 100 cycles needed
  initial
  begin
    #100us;
    num_errors++;
    report_and_stop();
  end
  initial
  begin
    rst();
    rd("fdir", 6'h30, 8'h00);
    rd("gdir", 6'h34, 8'h00);
    rd("hdir", 6'h38, 8'h00);
    `CHK("oe", 12'hFFF, oe_n)
    ext <= {2'h2, 3'h5, 7'h3A};
    rd("fpin", 6'h24, 8'h3A);
    rd("gpin", 6'h28, 8'h05);
    rd("hpin", 6'h2C, 8'h02);
    // Latches loaded before outputs are enabled
    xfer(1'b1, 6'h24, 8'h45);
    xfer(1'b1, 6'h28, 8'hFF);
    xfer(1'b1, 6'h2C, 8'hFF);
    rd("fin", 6'h24, 8'h3A);
    xfer(1'b1, 6'h30, 8'h7F);
    xfer(1'b1, 6'h34, 8'hFF);
    xfer(1'b1, 6'h38, 8'hFF);
    rd("gdir", 6'h34, 8'h07);
    rd("hdir", 6'h38, 8'h03);
    rd("flat", 6'h24, 8'h45);
    rd("glat", 6'h28, 8'h07);
    rd("hlat", 6'h2C, 8'h03);
    `CHK("oe", 12'h000, oe_n)
    `CHK("fout", 7'h45, outs[6:0])
    `CHK("gout", 3'h7, outs[9:7])
    `CHK("hout", 2'h3, outs[11:10])
    xfer(1'b1, 6'h30, 8'h0F);
    rd("fmix", 6'h24, 8'h35);
    els0 <= 2'h1;
    els1 <= 2'h2;
    tmr <= 2'b10;
    rd("ftim", 6'h24, 8'h25);
    `CHK("toe", 2'b00, oe_n[5:4])
    `CHK("tout", 2'b10, outs[5:4])
    `CHK("tpin", 2'b10, tbpin)
    els0 <= 2'h0;
    els1 <= 2'h0;
    kie <= 5'h1F;
    rd("gkbd", 6'h28, 8'h07);
    `CHK("toe", 2'b11, oe_n[5:4])
    `CHK("koe", 5'h1F, oe_n[11:7])
    `CHK("kwp", 5'h15, kwp)
    kie <= 5'h00;
    xfer(1'b1, 6'h3C, 8'h01);
    `CHK("err", 1'b1, got_err)
    rst();
    `CHK("oe", 12'hFFF, oe_n)
    xfer(1'b1, 6'h34, 8'h07);
    xfer(1'b1, 6'h38, 8'h03);
    rd("gkeep", 6'h28, 8'h07);
    rd("hkeep", 6'h2C, 8'h03);
    report_and_stop();
  end
endmodule : gpio_ports_f_g_h_test
`default_nettype wire
